// ---- rtl/bus_io_pkg.sv ----
// Shared constants for the host bus glue: bus timing, decode, bit layout.
// Assumes a single 50 MHz system clock from which the bus phase is made.
package bus_io_pkg;

  // Clocking
  localparam int MCLK_HZ        = 50_000_000;
  localparam int OSC_HZ         = 4_000_000;
  localparam int BUS_HZ         = 1_000_000;
  localparam int OSC_PER_BUS    = OSC_HZ / BUS_HZ;
  localparam int HALF_BUS_CYC   = MCLK_HZ / (2 * BUS_HZ);
  localparam int HALF_W         = $clog2(HALF_BUS_CYC);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(HALF_BUS_CYC - 1);

  // Bus widths and chip select decode
  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 8;
  localparam int SEL_HI         = 15;
  localparam int SEL_LO         = 12;
  localparam int SEL_W          = SEL_HI - SEL_LO + 1;
  localparam int NUM_CS         = 8;
  localparam int OUT_LATCH_CS   = 2;
  localparam int IN_BUF_CS      = 3;

  // Serial output latch layout
  localparam int NUM_BOARDS     = 4;
  localparam int LAT_BOARD_LO   = 0;
  localparam int LAT_TIMER_EN   = 4;
  localparam int LAT_EE_SEL     = 5;
  localparam int LAT_EE_CLK     = 6;
  localparam int LAT_EE_DIN     = 7;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;

  // Serial input buffer layout
  localparam int BUF_BOARD_LO   = 0;
  localparam int BUF_ZERO_LO    = 4;
  localparam int BUF_ZERO_W     = 3;
  localparam int BUF_EE_DOUT    = 7;

  // Tick timer
  localparam int TIMER_STAGES   = 14;
  localparam int TICK_TAP       = 12;

  // Bus cycle kinds
  typedef enum logic {
    CYC_WRITE,
    CYC_READ
  } cycle_kind_t;

endpackage : bus_io_pkg

// ---- rtl/chip_select_decoder.sv ----
// Chip select decoder: turns the high address lines into active-low selects.
// Purely combinational; the caller registers and times the result.
`timescale 1ns/1ns
module chip_select_decoder #(
  parameter int SEL_BITS = 4,
  parameter int SELECTS  = 8
) (
  // Address field
  input  wire logic [SEL_BITS-1:0] sel_field,
  // Decoded selects, active low
  output logic      [SELECTS-1:0]  sel_n
);

  always_comb begin
    sel_n = '1;
    // Indices past the last select leave every select inactive
    for (int i = 0; i < SELECTS; i++) begin
      if (sel_field == SEL_BITS'(i)) begin
        sel_n[i] = 1'b0;
      end
    end
  end

endmodule : chip_select_decoder

// ---- rtl/host_bus_io_port.sv ----
// Host bus glue: bus phase clock, chip select decode, read capture latch,
// write buffer, serial output latch, serial input buffer and tick timer.
// Assumes processor pins are synchronous to mclk; resetn is power clear.
//
// Functional notes
// - Bus runs a 1 MHz cycle from 4 MHz; phase clock is output.
// - Tick timer is a 14-stage counter of bus cycles, ticks near 4 ms.
// - Tick counter held at zero while timer enable is low.
// - Tick drives the processor interrupt input.
// - Read latch samples the data bus on each phase falling edge.
// - Write data goes around the read latch via the write buffer.
// - Active-low selects decoded from A12-A15 of 16 address lines.
// - Selected buffer drives bus; selected latch takes the bus data.
// - Free-run mode forces the no-operation code to processor data.
// - Buffer D0-D3 carry board returns, D7 the EEPROM data out.
// - Buffer D4-D6 always read zero.
// - Buffer outputs released whenever its select is not decoded.
// - Output latch captures all eight lines on its select rising edge.
// - Latch D0-D3 board data, D4 timer, D5-D7 EEPROM pins.
// - Power gate low forces the EEPROM clock inactive.
// - Power clear held low at power on initialises the logic.
`timescale 1ns/1ns
module host_bus_io_port
  import bus_io_pkg::*;
#(
  parameter logic [bus_io_pkg::DATA_W-1:0] NOP_CODE = 8'h00,
  // Tick counter length and the stage whose fall makes the tick
  parameter int TICK_STAGES  = bus_io_pkg::TIMER_STAGES,
  parameter int TICK_TAP_BIT = bus_io_pkg::TICK_TAP
) (
  // Clock and power clear
  input  wire logic                                mclk,
  input  wire logic                                resetn,
  // Processor side
  input  wire logic [bus_io_pkg::ADDR_W-1:0]       cpu_addr,
  input  wire logic                                cpu_rw,
  input  wire logic [bus_io_pkg::DATA_W-1:0]       cpu_wdata,
  output logic      [bus_io_pkg::DATA_W-1:0]       cpu_rdata,
  output logic                                     cpu_irq,
  output logic                                     bus_phase,
  // Test strap
  input  wire logic                                free_run_jumper,
  // System data bus
  input  wire logic [bus_io_pkg::DATA_W-1:0]       sys_data_in,
  output logic      [bus_io_pkg::DATA_W-1:0]       sys_data_out,
  output logic                                     sys_data_oe,
  // Chip selects, active low
  output logic      [bus_io_pkg::NUM_CS-1:0]       chip_sel_n,
  // Output boards
  output logic      [bus_io_pkg::NUM_BOARDS-1:0]   board_tx,
  input  wire logic [bus_io_pkg::NUM_BOARDS-1:0]   board_rx,
  // Serial EEPROM
  input  wire logic                                eeprom_power_gate,
  output logic                                     eeprom_sel,
  output logic                                     eeprom_clk,
  output logic                                     eeprom_din,
  input  wire logic                                eeprom_dout
);

  import bus_io_pkg::*;

  logic [HALF_W-1:0] half_cnt_r;
  logic              phase_r;
  logic              rise_evt;
  logic              fall_evt;
  logic [NUM_CS-1:0] decode_n;
  logic [NUM_CS-1:0] sel_n_r;
  logic [DATA_W-1:0] out_latch_r;
  logic [DATA_W-1:0] in_buffer;
  logic [DATA_W-1:0] bus_level;
  logic [DATA_W-1:0] sys_out_r;
  logic              sys_oe_r;
  logic [DATA_W-1:0] rdata_r;
  logic              tick;
  logic              irq_r;
  logic              ee_clk_r;

  // Bus phase clock. The 4 MHz oscillator divided by OSC_PER_BUS is
  // modelled directly from mclk, since 50 MHz does not divide to 4 MHz.
  assign rise_evt = (half_cnt_r == HALF_LAST) && !phase_r;
  assign fall_evt = (half_cnt_r == HALF_LAST) && phase_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      half_cnt_r <= '0;
    end else if (half_cnt_r == HALF_LAST) begin
      half_cnt_r <= '0;
    end else begin
      half_cnt_r <= half_cnt_r + HALF_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 1'b0;
    end else if (rise_evt || fall_evt) begin
      phase_r <= ~phase_r;
    end
  end

  assign bus_phase = phase_r;

  // Address decode from the top four address lines
  chip_select_decoder #(
    .SELECTS  (NUM_CS),
    .SEL_BITS (SEL_W)
  ) u_decoder (
    .sel_field (cpu_addr[SEL_HI:SEL_LO]),
    .sel_n     (decode_n)
  );

  // Selects are taken at the rising edge, when the address is valid,
  // and dropped at the falling edge. Dropping them there is what makes
  // the read latch necessary.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_n_r <= '1;
    end else if (rise_evt) begin
      sel_n_r <= decode_n;
    end else if (fall_evt) begin
      sel_n_r <= '1;
    end
  end

  assign chip_sel_n = sel_n_r;

  // Serial input buffer contents
  always_comb begin
    in_buffer = '0;
    in_buffer[BUF_BOARD_LO +: NUM_BOARDS] = board_rx;
    in_buffer[BUF_EE_DOUT] = eeprom_dout;
    in_buffer[BUF_ZERO_LO +: BUF_ZERO_W] = '0;
  end

  // Drive onto the system bus: write buffer in write cycles, input
  // buffer in a selected read, released otherwise.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sys_out_r <= '0;
      sys_oe_r  <= 1'b0;
    end else if (rise_evt) begin
      if (!cpu_rw) begin
        sys_out_r <= cpu_wdata;
        sys_oe_r  <= 1'b1;
      end else if (!decode_n[IN_BUF_CS]) begin
        sys_out_r <= in_buffer;
        sys_oe_r  <= 1'b1;
      end else begin
        sys_out_r <= '0;
        sys_oe_r  <= 1'b0;
      end
    end else if (fall_evt) begin
      sys_out_r <= '0;
      sys_oe_r  <= 1'b0;
    end
  end

  assign sys_data_out = sys_out_r;
  assign sys_data_oe  = sys_oe_r;

  // Level seen on the system bus when this block drives it or not
  assign bus_level = sys_oe_r ? sys_out_r : sys_data_in;

  // Read capture latch; free-run forces the no-operation code so the
  // processor walks the whole address space.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else if (free_run_jumper) begin
      rdata_r <= NOP_CODE;
    end else if (fall_evt) begin
      rdata_r <= bus_level;
    end
  end

  assign cpu_rdata = rdata_r;

  // Serial output latch: captured as its select returns high, i.e. at
  // the falling phase edge of a cycle in which it was selected.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_latch_r <= LATCH_RESET;
    end else if (fall_evt && !sel_n_r[OUT_LATCH_CS]) begin
      out_latch_r <= bus_level;
    end
  end

  // Board serial lines and EEPROM pins. The processor bit-bangs the
  // board and EEPROM protocols; this block only carries the bits.
  assign board_tx   = out_latch_r[LAT_BOARD_LO +: NUM_BOARDS];
  assign eeprom_sel = out_latch_r[LAT_EE_SEL];
  assign eeprom_din = out_latch_r[LAT_EE_DIN];

  // EEPROM clock is gated off while power is not yet good, so a
  // glitching latch at power on cannot clock a write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ee_clk_r <= 1'b0;
    end else begin
      ee_clk_r <= out_latch_r[LAT_EE_CLK] & eeprom_power_gate;
    end
  end

  assign eeprom_clk = ee_clk_r;

  // Tick timer stepped by bus cycles, enabled by latch bit D4
  tick_timer #(
    .STAGES (TICK_STAGES),
    .TAP    (TICK_TAP_BIT)
  ) u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .step   (rise_evt),
    .enable (out_latch_r[LAT_TIMER_EN]),
    .tick   (tick)
  );

  // Interrupt held until the next bus phase rising edge so the processor sees it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (tick) begin
      irq_r <= 1'b1;
    end else if (rise_evt) begin
      irq_r <= 1'b0;
    end
  end

  assign cpu_irq = irq_r;

endmodule : host_bus_io_port

// ---- rtl/tick_timer.sv ----
// Periodic tick: a cleared-when-disabled ripple-style divider of bus cycles.
// Assumes step is a one-cycle pulse at each bus phase rising edge.
`timescale 1ns/1ns
module tick_timer #(
  parameter int STAGES = 14,
  parameter int TAP    = 12
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Control
  input  wire logic step,
  input  wire logic enable,
  // Tick out, one mclk cycle
  output logic      tick
);

  logic [STAGES-1:0] count_r;
  logic              tap_prev_r;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_r <= '0;
    end else if (!enable) begin
      count_r <= '0;
    end else if (step) begin
      count_r <= count_r + STAGES'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tap_prev_r <= 1'b0;
    end else begin
      tap_prev_r <= count_r[TAP-1];
    end
  end

  // Falling edge of the tap stage: one tick per 2**TAP bus cycles.
  // Clearing the counter on disable is not a tick, hence the gate.
  assign tick = enable & tap_prev_r & ~count_r[TAP-1];

endmodule : tick_timer

// ---- testbench/bus_io_monitor.sv ----
// Checker for the host bus glue, watching the top module's ports only.
// Assumes the default free-run code of all zeros.
`timescale 1ns/1ns
module bus_io_monitor (
  // Clock and power clear
  input wire logic        mclk,
  input wire logic        resetn,
  // Processor side
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rw,
  input wire logic [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata,
  input wire logic        cpu_irq,
  input wire logic        bus_phase,
  input wire logic        free_run_jumper,
  // System bus and selects
  input wire logic [7:0]  sys_data_in,
  input wire logic [7:0]  sys_data_out,
  input wire logic        sys_data_oe,
  input wire logic [7:0]  chip_sel_n,
  // EEPROM
  input wire logic        eeprom_power_gate,
  input wire logic        eeprom_clk
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    $rose(bus_phase);
  endsequence
  sequence s_end;
    $fell(bus_phase);
  endsequence
  a_phase_high: assert property (s_start |-> ##24 bus_phase ##1 !bus_phase)
    else $error("bus phase high half has the wrong length");
  a_sel_decode: assert property (s_start |=>
    chip_sel_n == ~(8'h01 << cpu_addr[15:12]))
    else $error("chip select does not match the address");
  a_sel_release: assert property (s_end |=> &chip_sel_n)
    else $error("chip select held past the cycle");
  a_buf_zero: assert property (s_start ##0 (cpu_rw && cpu_addr[15:12] == 4'h3)
    |=> sys_data_oe && sys_data_out[6:4] == 3'b000)
    else $error("buffer read not driven or unused bits set");
  a_buf_release: assert property (s_start ##0 (cpu_rw && cpu_addr[15:12] != 4'h3)
    |=> !sys_data_oe)
    else $error("bus driven on an unselected read");
  a_write_path: assert property (s_start ##0 !cpu_rw
    |=> sys_data_oe && sys_data_out == cpu_wdata)
    else $error("write data not passed to the system bus");
  a_read_capture: assert property (s_end ##0 !free_run_jumper
    ##0 !$past(free_run_jumper) |=> free_run_jumper
    || cpu_rdata == ($past(sys_data_oe, 2) ? $past(sys_data_out, 2)
    : $past(sys_data_in, 2)))
    else $error("read latch missed the bus level");
  a_free_run: assert property (free_run_jumper[*2] |-> cpu_rdata == 8'h00)
    else $error("free-run code not forced");
  a_ee_gate: assert property (!eeprom_power_gate |=> !eeprom_clk)
    else $error("eeprom clock active while power gated");
  a_irq_short: assert property ($rose(cpu_irq) |-> ##[1:51] !cpu_irq)
    else $error("interrupt pulse too long");
endmodule : bus_io_monitor

bind host_bus_io_port bus_io_monitor u_bus_io_monitor (.mclk, .resetn,
  .cpu_addr, .cpu_rw, .cpu_wdata, .cpu_rdata, .cpu_irq, .bus_phase,
  .free_run_jumper, .sys_data_in, .sys_data_out, .sys_data_oe,
  .chip_sel_n, .eeprom_power_gate, .eeprom_clk);

// ---- testbench/cpu_bus_model.sv ----
// Processor model: runs one bus cycle per call on the host bus glue.
// Assumes bus_phase marks the start and end of each cycle.
`timescale 1ns/1ns
module cpu_bus_model (
  // Clock and bus phase
  input wire logic        mclk,
  input wire logic        bus_phase,
  // Processor pins
  output logic     [15:0] cpu_addr,
  output logic            cpu_rw,
  output logic     [7:0]  cpu_wdata,
  input wire logic [7:0]  cpu_rdata
);
  initial begin
    cpu_addr = 16'h8000;
    cpu_rw = 1'b1;
    cpu_wdata = 8'h00;
  end
  task automatic cycle(input logic [15:0] a, input logic rw,
                       input logic [7:0] wd, output logic [7:0] rd);
    @(negedge mclk);
    while (bus_phase) @(negedge mclk);
    // Address set up well before the phase rise and held to the end
    cpu_addr = a;
    cpu_rw = rw;
    // On reads the data lines take the inverse of their last value, so no stale value may linger
    cpu_wdata = rw ? ~cpu_wdata : wd;
    @(posedge bus_phase);
    @(negedge bus_phase);
    repeat (3) @(negedge mclk);
    rd = cpu_rdata;
  endtask : cycle
endmodule : cpu_bus_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the host bus glue with a processor model.
// Assumes the design's default free-run code and a 50 MHz clock.
`timescale 1ns/1ns
module testbench;
  import bus_io_pkg::*;
  typedef struct packed {
    logic [3:0] idx;
    logic       rw;
    logic [7:0] wd;
    logic [4:0] rx;
    logic [7:0] exp;
  } row_t;
  logic mclk = 0, resetn = 0, cpu_rw, cpu_irq, bus_phase, sys_data_oe;
  logic free_run_jumper = 0, eeprom_power_gate = 1, eeprom_dout = 0;
  logic eeprom_sel, eeprom_clk, eeprom_din;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, sys_data_out, chip_sel_n, rd, e;
  logic [7:0] sys_data_in = 8'h3C;
  logic [3:0] board_tx, board_rx = 4'h0;
  int err_total = 0, checked = 0, cycles = 0, n, m;
  // A short tick tap keeps the interrupt test inside the run budget
  localparam int TAP_BENCH = 3;
  localparam int BUS_CYC = MCLK_HZ / BUS_HZ;
  localparam int TICK_MIN = (2**TAP_BENCH - 1) * BUS_CYC;
  localparam int TICK_MAX = 2**TAP_BENCH * BUS_CYC;
  logic [3:0] ee_bits = 4'hB;
  // Latch side effect: a read of the latch loads the undriven bus level
  row_t rows [7] = '{'{4'h2, 1'b0, 8'hA5, 5'h00, 8'hA5},
    '{4'h2, 1'b0, 8'h5A, 5'h00, 8'h5A}, '{4'h3, 1'b1, 8'h00, 5'h16, 8'h86},
    '{4'h3, 1'b1, 8'h00, 5'h09, 8'h09}, '{4'h2, 1'b1, 8'h00, 5'h00, 8'h3C},
    '{4'h9, 1'b1, 8'h00, 5'h1F, 8'h3C}, '{4'h9, 1'b0, 8'h77, 5'h00, 8'h77}};
  always #10 mclk = ~mclk;
  host_bus_io_port #(.TICK_TAP_BIT(TAP_BENCH)) u_host_bus_io_port (
    .mclk, .resetn, .cpu_addr, .cpu_rw,
    .cpu_wdata, .cpu_rdata, .cpu_irq, .bus_phase, .free_run_jumper,
    .sys_data_in, .sys_data_out, .sys_data_oe, .chip_sel_n, .board_tx,
    .board_rx, .eeprom_power_gate, .eeprom_sel, .eeprom_clk, .eeprom_din,
    .eeprom_dout);
  cpu_bus_model u_cpu_bus_model (.mclk, .bus_phase, .cpu_addr, .cpu_rw,
    .cpu_wdata, .cpu_rdata);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  function automatic logic [7:0] latch_view();
    return {eeprom_din, eeprom_clk, eeprom_sel, 1'b0, board_tx};
  endfunction : latch_view
  // Run takes under 2500 cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (19) @(negedge mclk);
    chk(chip_sel_n, 8'hFF);
    chk(latch_view(), 8'h00);
    @(negedge mclk);
    resetn = 1;
    foreach (rows[i]) begin
      {eeprom_dout, board_rx} = rows[i].rx;
      u_cpu_bus_model.cycle({rows[i].idx, 12'h123}, rows[i].rw, rows[i].wd, rd);
      chk(rd, rows[i].exp);
      e = rows[i].rw ? sys_data_in : rows[i].wd;
      if (rows[i].idx == 4'h2) chk(latch_view(), {e[7:5], 1'b0, e[3:0]});
    end
    $display("table test done");
    // EEPROM bits go out on D5-D7 of the latch and come back on D7
    for (int i = 0; i < 4; i++) begin
      u_cpu_bus_model.cycle(16'h2000, 1'b0, {ee_bits[i], 7'h60}, rd);
      chk(latch_view(), {ee_bits[i], 7'h60});
      eeprom_dout = ee_bits[i];
      u_cpu_bus_model.cycle(16'h3000, 1'b1, 8'h00, rd);
      chk(rd, {ee_bits[i], 7'h00});
    end
    $display("eeprom test done");
    eeprom_power_gate = 0;
    u_cpu_bus_model.cycle(16'h2000, 1'b0, 8'h40, rd);
    chk(latch_view(), 8'h00);
    eeprom_power_gate = 1;
    repeat (2) @(negedge mclk);
    chk(latch_view(), 8'h40);
    $display("power gate test done");
    u_cpu_bus_model.cycle(16'h2000, 1'b0, 8'h10, rd);
    n = 0;
    while (cpu_irq !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(n >= TICK_MIN && n <= TICK_MAX), 8'h01);
    m = 0;
    while (cpu_irq === 1'b1 && m < 100) begin
      @(negedge mclk);
      m++;
    end
    chk(8'(m >= BUS_CYC - 5 && m <= BUS_CYC), 8'h01);
    u_cpu_bus_model.cycle(16'h2000, 1'b0, 8'h00, rd);
    m = 0;
    repeat (10 * BUS_CYC) begin
      @(negedge mclk);
      if (cpu_irq !== 1'b0) m++;
    end
    chk(8'(m), 8'h00);
    $display("timer test done");
    free_run_jumper = 1;
    repeat (3) @(negedge mclk);
    chk(cpu_rdata, 8'h00);
    free_run_jumper = 0;
    $display("free-run test done");
    resetn = 0;
    @(negedge mclk);
    chk(latch_view(), 8'h00);
    chk(chip_sel_n, 8'hFF);
    resetn = 1;
    u_cpu_bus_model.cycle(16'h3000, 1'b1, 8'h00, rd);
    chk(rd, {eeprom_dout, 3'b000, board_rx});
    $display("second reset test done");
    end_of_test();
  end
endmodule : testbench
